// ===== src/hwcf_pkg.sv
package hwcf_pkg;
  // Register map of the device end
  localparam logic [7:0]  HWCF_OFF_CONFIG     = 8'h74;
  localparam logic [7:0]  HWCF_OFF_RX_DROP    = 8'h78;
  localparam logic [7:0]  HWCF_OFF_PART_TX    = 8'h7C;
  localparam logic [7:0]  HWCF_OFF_PART_RX    = 8'h80;
  localparam logic [7:0]  HWCF_OFF_ERR        = 8'h84;
  // Field positions in hardware_configuration
  localparam int          HWCF_BIT_REQ_ONE    = 20;
  localparam int          HWCF_LSB_TX_SIZE    = 16;
  localparam int          HWCF_BIT_BUS_WIDTH  = 2;
  localparam int          HWCF_BIT_RST_TMO    = 1;
  localparam int          HWCF_BIT_SOFT_RST   = 0;
  localparam logic [3:0]  HWCF_TX_SIZE_RST    = 4'h5;
  // Sizes in bytes, and the TX buffer frame limit
  localparam logic [15:0] HWCF_TOTAL_BYTES    = 16'h4000;
  localparam logic [15:0] HWCF_TX_STAT_BYTES  = 16'h0200;
  localparam logic [15:0] HWCF_RX_FULL_MARGIN = 16'h0010;
  localparam logic [15:0] HWCF_BUF_TX_BYTES   = 16'h0800;
  localparam logic [15:0] HWCF_BUF_RX_BYTES   = 16'h0080;
  localparam logic [15:0] HWCF_BUF_TX_FRAMES  = 16'h0002;
  // Cycles that a soft reset waits for the link clocks
  localparam int          HWCF_RST_TMO_NS     = 2000;
  localparam int          HWCF_CLK_NS         = 40;
  localparam int          HWCF_RST_TMO_CYC    = HWCF_RST_TMO_NS / HWCF_CLK_NS;
  localparam logic [1:0]  HWCF_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  HWCF_RESP_SLVERR    = 2'h2;
endpackage

// ===== src/hwcf_if.sv
interface hwcf_if;
  logic [31:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [31:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  modport dev (input awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
               output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid);
  modport host (output awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready,
                input awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid);
endinterface

// ===== src/hwcf_dev.sv
// Contract
// R1: Host halts TX and RX before configuring
// R2: Host sets required one bit; resets zero
// R3: TX allocation field bits 19:16, reset 5
// R4: 512 bytes of TX allocation hold status
// R5: Host keeps TX allocation at least 2KB
// R6: TX data queue holds commands and payload
// R7: RX gets 16384 minus TX allocation
// R8: RX status is one sixteenth of RX
// R9: Host programs only allocation codes 2..14
// R10: RX data full four words early
// R11: Bit 2 shows sampled bus width strap
// R12: Reset without PHY clocks sets time-out
// R13: Soft reset clears registers and error flags
// R14: Host waits for PHY, retries after time-out; hwcf_host does neither
// R15: Writes ignored until one read done
// R16: Fixed MAC buffers 2K TX, 128 RX
// R17: TX moves to MAC buffer, two frames
// R18: RX through MAC buffer; overrun drops frames
// R19: Each dropped frame increments drop counter
// R20: MAC buffer levels hidden from host
//
// Local design decision: register access over AXI4-Lite.
module hwcf_dev
  import hwcf_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Register bus
  hwcf_if.dev              bus,
  // Pins and user side
  input  wire logic        bus_width_strap,
  input  wire logic        phy_clocks_running,
  input  wire logic        tx_word_from_queue,
  input  wire logic        tx_frame_end,
  input  wire logic        tx_mac_word_sent,
  input  wire logic        rx_mac_word,
  input  wire logic        rx_mac_frame_start,
  input  wire logic        rx_queue_word_read,
  input  wire logic        transmit_error_in,
  input  wire logic        receive_error_in,
  output logic             tx_buf_accept,
  output logic             rx_queue_full,
  output logic [15:0]      tx_data_bytes,
  output logic [15:0]      rx_data_bytes,
  output logic [15:0]      rx_stat_bytes,
  output logic             mac_reset
);
  import hwcf_pkg::*;

  typedef enum logic [2:0] {
    HWCF_IDLE = 3'b001,
    HWCF_SOFT = 3'b010,
    HWCF_BRSP = 3'b100
  } hwcf_wst_t;

  typedef struct packed {
    logic [1:0]  strap_sync;
    logic [1:0]  phy_sync;
    logic        bus_width;
    logic        req_one;
    logic [3:0]  tx_size;
    logic        rst_tmo;
    logic [7:0]  rst_cnt;
    logic        read_seen;
    hwcf_wst_t   wst;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_off;
    logic [31:0] wdat;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [15:0] tx_buf_lvl;
    logic [1:0]  tx_buf_frames;
    logic [15:0] rx_buf_lvl;
    logic        rx_dropping;
    logic [15:0] rx_q_lvl;
    logic [31:0] drop_cnt;
    logic        tx_err;
    logic        rx_err;
    logic        tx_acc;
    logic        rx_full;
    logic [15:0] tx_bytes;
    logic [15:0] rx_bytes;
    logic [15:0] rx_sbytes;
    logic        mac_rst;
  } hwcf_dev_st_t;

  hwcf_dev_st_t st_r;
  hwcf_dev_st_t st_nxt;

  function automatic logic [15:0] tx_total(input logic [3:0] sz);
    tx_total = {2'h0, sz, 10'h000};
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] off, input hwcf_dev_st_t s);
    read_word = 32'h0000_0000;
    case (off)
      HWCF_OFF_CONFIG: begin
        read_word[HWCF_BIT_REQ_ONE]                      = s.req_one;
        read_word[HWCF_LSB_TX_SIZE +: 4]                 = s.tx_size;
        read_word[HWCF_BIT_BUS_WIDTH]                    = s.bus_width; // R11
        read_word[HWCF_BIT_RST_TMO]                      = s.rst_tmo;
      end
      HWCF_OFF_RX_DROP: read_word = s.drop_cnt;
      HWCF_OFF_PART_TX: read_word = {s.tx_bytes, HWCF_TX_STAT_BYTES};
      HWCF_OFF_PART_RX: read_word = {s.rx_bytes, s.rx_sbytes};
      HWCF_OFF_ERR:     read_word = {30'h0000_0000, s.rx_err, s.tx_err};
      default:          read_word = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] off);
    mapped = (off == HWCF_OFF_CONFIG) || (off == HWCF_OFF_RX_DROP) ||
             (off == HWCF_OFF_PART_TX) || (off == HWCF_OFF_PART_RX) ||
             (off == HWCF_OFF_ERR);
  endfunction

  logic [15:0] rx_alloc;
  logic [15:0] rx_cap;
  logic        rx_to_queue;
  logic        buf_rx_room;

  always_comb begin
    st_nxt = st_r;
    rx_alloc = HWCF_TOTAL_BYTES - tx_total(st_r.tx_size); // R7
    rx_cap   = rx_alloc - {4'h0, rx_alloc[15:4]};         // R8
    rx_to_queue = 1'b0;
    buf_rx_room = 1'b0;

    st_nxt.strap_sync = {st_r.strap_sync[0], bus_width_strap};
    st_nxt.phy_sync   = {st_r.phy_sync[0], phy_clocks_running};
    st_nxt.bus_width  = st_r.strap_sync[1];

    // Partition outputs and the full flag, recomputed every cycle from the size field and queue level
    st_nxt.tx_bytes  = tx_total(st_r.tx_size) - HWCF_TX_STAT_BYTES; // R3 R4 R6
    st_nxt.rx_bytes  = rx_cap;
    st_nxt.rx_sbytes = {4'h0, rx_alloc[15:4]}; // R8
    st_nxt.rx_full   = (st_r.rx_q_lvl + HWCF_RX_FULL_MARGIN) >= rx_cap; // R10

    // TX MAC buffer: take a word while room and under two frames queued
    st_nxt.tx_acc = (st_r.tx_buf_lvl + 16'h0004 <= HWCF_BUF_TX_BYTES) &&
                    (16'(st_r.tx_buf_frames) < HWCF_BUF_TX_FRAMES); // R16 R17
    if (tx_word_from_queue && st_r.tx_acc) begin
      st_nxt.tx_buf_lvl = st_r.tx_buf_lvl + 16'h0004; // R17
      if (tx_frame_end) begin
        st_nxt.tx_buf_frames = st_r.tx_buf_frames + 2'h1;
      end
    end
    if (tx_mac_word_sent && st_r.tx_buf_lvl != 16'h0000) begin
      st_nxt.tx_buf_lvl = st_nxt.tx_buf_lvl - 16'h0004;
    end
    // No sent-frame strobe exists, so queued frames are freed once the buffer drains
    if (st_nxt.tx_buf_lvl == 16'h0000) begin
      st_nxt.tx_buf_frames = 2'h0;
    end

    // RX: MAC buffer drains into queue unless queue is full
    if (st_r.rx_buf_lvl != 16'h0000 && !st_r.rx_full) begin
      rx_to_queue = 1'b1; // R18
      st_nxt.rx_buf_lvl = st_r.rx_buf_lvl - 16'h0004;
    end
    buf_rx_room = (st_nxt.rx_buf_lvl + 16'h0004) <= HWCF_BUF_RX_BYTES;
    if (rx_mac_frame_start) begin
      st_nxt.rx_dropping = !buf_rx_room;
      if (!buf_rx_room) begin
        st_nxt.drop_cnt = st_r.drop_cnt + 32'h0000_0001; // R19
      end
    end
    if (rx_mac_word && !st_nxt.rx_dropping) begin
      if (buf_rx_room) begin
        st_nxt.rx_buf_lvl = st_nxt.rx_buf_lvl + 16'h0004;
      end else begin
        st_nxt.rx_dropping = 1'b1; // R18
        st_nxt.drop_cnt = st_r.drop_cnt + 32'h0000_0001; // R19
      end
    end
    // Queue level counts only host-visible data
    if (rx_to_queue && !(rx_queue_word_read && st_r.rx_q_lvl != 16'h0000)) begin
      st_nxt.rx_q_lvl = st_r.rx_q_lvl + 16'h0004; // R20
    end else if (!rx_to_queue && rx_queue_word_read && st_r.rx_q_lvl != 16'h0000) begin
      st_nxt.rx_q_lvl = st_r.rx_q_lvl - 16'h0004;
    end

    // Error flags are sticky; a new error wins over the soft reset clear
    if (transmit_error_in) st_nxt.tx_err = 1'b1;
    if (receive_error_in)  st_nxt.rx_err = 1'b1;
    st_nxt.mac_rst = 1'b0;

    // Read channel
    if (st_r.rvalid) begin
      if (bus.rready) st_nxt.rvalid = 1'b0;
    end else if (bus.arvalid) begin
      st_nxt.rvalid    = 1'b1;
      st_nxt.rdata     = read_word(bus.araddr[7:0], st_r);
      st_nxt.rresp     = mapped(bus.araddr[7:0]) ? HWCF_RESP_OKAY : HWCF_RESP_SLVERR;
      st_nxt.read_seen = 1'b1; // R15
    end

    // Write channels
    if (bus.awvalid && !st_r.aw_got && st_r.wst == HWCF_IDLE) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_off = bus.awaddr[7:0];
    end
    if (bus.wvalid && !st_r.w_got && st_r.wst == HWCF_IDLE) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdat  = bus.wdata;
    end

    case (st_r.wst)
      HWCF_IDLE: begin
        if (st_r.aw_got && st_r.w_got) begin
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got  = 1'b0;
          st_nxt.bresp  = mapped(st_r.aw_off) ? HWCF_RESP_OKAY : HWCF_RESP_SLVERR;
          st_nxt.wst    = HWCF_BRSP;
          // Writes before the first read are dropped but still answered
          if (st_r.read_seen && st_r.aw_off == HWCF_OFF_CONFIG) begin // R15
            st_nxt.req_one = st_r.wdat[HWCF_BIT_REQ_ONE];
            st_nxt.tx_size = st_r.wdat[HWCF_LSB_TX_SIZE +: 4]; // R3
            if (st_r.wdat[HWCF_BIT_SOFT_RST]) begin
              st_nxt.rst_cnt = 8'h00;
              st_nxt.wst     = HWCF_SOFT;
            end
          end
        end
      end
      HWCF_SOFT: begin
        if (st_r.phy_sync[1]) begin
          // Clocks present: full reset of control state and errors
          st_nxt.req_one  = 1'b0; // R13
          st_nxt.tx_size  = HWCF_TX_SIZE_RST;
          st_nxt.rst_tmo  = 1'b0;
          st_nxt.drop_cnt = st_nxt.drop_cnt - st_r.drop_cnt; // A drop this cycle survives
          st_nxt.tx_err   = transmit_error_in;
          st_nxt.rx_err   = receive_error_in;
          st_nxt.mac_rst  = 1'b1;
          st_nxt.wst      = HWCF_BRSP;
        end else if (st_r.rst_cnt == 8'(HWCF_RST_TMO_CYC - 1)) begin
          st_nxt.rst_tmo = 1'b1; // R12
          st_nxt.wst     = HWCF_BRSP;
        end else begin
          st_nxt.rst_cnt = st_r.rst_cnt + 8'h01;
        end
      end
      HWCF_BRSP: begin
        if (bus.bready) st_nxt.wst = HWCF_IDLE;
      end
      default: st_nxt.wst = HWCF_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r         <= '0;
      st_r.tx_size <= HWCF_TX_SIZE_RST; // R3
      st_r.wst     <= HWCF_IDLE;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign bus.awready   = (st_r.wst == HWCF_IDLE) && !st_r.aw_got;
  assign bus.wready    = (st_r.wst == HWCF_IDLE) && !st_r.w_got;
  assign bus.bvalid    = (st_r.wst == HWCF_BRSP);
  assign bus.bresp     = st_r.bresp;
  assign bus.arready   = !st_r.rvalid;
  assign bus.rvalid    = st_r.rvalid;
  assign bus.rdata     = st_r.rdata;
  assign bus.rresp     = st_r.rresp;
  assign tx_buf_accept = st_r.tx_acc;
  assign rx_queue_full = st_r.rx_full;
  assign tx_data_bytes = st_r.tx_bytes;
  assign rx_data_bytes = st_r.rx_bytes;
  assign rx_stat_bytes = st_r.rx_sbytes;
  assign mac_reset     = st_r.mac_rst;
endmodule

// ===== src/hwcf_host.sv
module hwcf_host
  import hwcf_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Register bus
  hwcf_if.host             bus,
  // Command port
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_off,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic        paths_halted,
  output logic             cmd_ready,
  output logic             done,
  output logic [31:0]      done_rdata,
  output logic [1:0]       done_resp,
  output logic             cmd_refused
);
  import hwcf_pkg::*;

  typedef enum logic [2:0] {
    HWCF_H_IDLE = 3'b001,
    HWCF_H_WR   = 3'b010,
    HWCF_H_RD   = 3'b100
  } hwcf_hst_t;

  typedef struct packed {
    hwcf_hst_t   st;
    logic        awv;
    logic        wv;
    logic        arv;
    logic        brdy;
    logic        rrdy;
    logic [31:0] addr;
    logic [31:0] wdat;
    logic        done;
    logic [31:0] rdat;
    logic [1:0]  resp;
    logic        refused;
  } hwcf_host_st_t;

  hwcf_host_st_t s_r;
  hwcf_host_st_t s_nxt;

  function automatic logic cfg_ok(input logic [7:0] off, input logic [31:0] d);
    // Allocation 2..14 and the required bit set
    cfg_ok = (off != HWCF_OFF_CONFIG) ||
             (d[HWCF_BIT_REQ_ONE] && d[HWCF_LSB_TX_SIZE +: 4] >= 4'h2 &&
              d[HWCF_LSB_TX_SIZE +: 4] <= 4'hE); // R2 R5 R9
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.refused = 1'b0;
    case (s_r.st)
      HWCF_H_IDLE: begin
        if (cmd_valid) begin
          s_nxt.addr = {24'h000000, cmd_off};
          s_nxt.wdat = cmd_wdata;
          if (!cmd_write) begin
            s_nxt.arv  = 1'b1;
            s_nxt.rrdy = 1'b1;
            s_nxt.st   = HWCF_H_RD;
          end else if (cmd_off == HWCF_OFF_CONFIG && !paths_halted) begin
            s_nxt.refused = 1'b1; // R1
          end else if (!cfg_ok(cmd_off, cmd_wdata)) begin
            s_nxt.refused = 1'b1; // R9
          end else begin
            s_nxt.awv  = 1'b1;
            s_nxt.wv   = 1'b1;
            s_nxt.brdy = 1'b1;
            s_nxt.st   = HWCF_H_WR;
          end
        end
      end
      HWCF_H_WR: begin
        if (bus.awready) s_nxt.awv = 1'b0;
        if (bus.wready)  s_nxt.wv  = 1'b0;
        if (bus.bvalid && !s_r.awv && !s_r.wv) begin
          s_nxt.brdy = 1'b0;
          s_nxt.resp = bus.bresp;
          s_nxt.done = 1'b1;
          s_nxt.st   = HWCF_H_IDLE;
        end
      end
      HWCF_H_RD: begin
        if (bus.arready) s_nxt.arv = 1'b0;
        if (bus.rvalid) begin
          s_nxt.rrdy = 1'b0;
          s_nxt.rdat = bus.rdata;
          s_nxt.resp = bus.rresp;
          s_nxt.done = 1'b1;
          s_nxt.st   = HWCF_H_IDLE;
        end
      end
      default: s_nxt.st = HWCF_H_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r    <= '0;
      s_r.st <= HWCF_H_IDLE;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign bus.awaddr  = s_r.addr;
  assign bus.awvalid = s_r.awv;
  assign bus.wdata   = s_r.wdat;
  assign bus.wstrb   = 4'hF;
  assign bus.wvalid  = s_r.wv;
  assign bus.bready  = s_r.brdy;
  assign bus.araddr  = s_r.addr;
  assign bus.arvalid = s_r.arv;
  assign bus.rready  = s_r.rrdy;
  assign cmd_ready   = (s_r.st == HWCF_H_IDLE);
  assign done        = s_r.done;
  assign done_rdata  = s_r.rdat;
  assign done_resp   = s_r.resp;
  assign cmd_refused = s_r.refused;
endmodule

// ===== tb/hwcf_asserts.sv
module hwcf_asserts
  import hwcf_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write channels
  input wire logic [31:0] awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  // Read channels
  input wire logic [31:0] araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_aw_hold; awvalid && !awready |=> awvalid && $stable(awaddr); endproperty
  a_aw_hold: assert property (p_aw_hold)
    else $error("write address released early");
  property p_w_hold; wvalid && !wready |=> wvalid && $stable(wdata); endproperty
  a_w_hold: assert property (p_w_hold)
    else $error("write data released early");
  property p_ar_hold; arvalid && !arready |=> arvalid && $stable(araddr); endproperty
  a_ar_hold: assert property (p_ar_hold)
    else $error("read address released early");
  property p_b_stand; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_stand: assert property (p_b_stand)
    else $error("write response withdrawn");
  property p_r_stand; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_r_stand: assert property (p_r_stand)
    else $error("read data withdrawn");
  property p_r_latency; arvalid && arready && !rvalid |=> rvalid; endproperty
  a_r_latency: assert property (p_r_latency)
    else $error("read answer late");
  // Soft reset may wait out its time-out before answering
  property p_b_bound; awvalid && awready |-> ##[1:80] bvalid; endproperty
  a_b_bound: assert property (p_b_bound)
    else $error("write answer missing");
  property p_resp_code;
    bvalid |-> bresp == HWCF_RESP_OKAY || bresp == HWCF_RESP_SLVERR;
  endproperty
  a_resp_code: assert property (p_resp_code)
    else $error("bad write response code");
  property p_bready_hold; bready && !bvalid |=> bready; endproperty
  a_bready_hold: assert property (p_bready_hold)
    else $error("bready dropped before response");

  c_read: cover property (rvalid && rready);
  c_write: cover property (bvalid && bready);
  c_slverr: cover property (rvalid && rresp == HWCF_RESP_SLVERR);
endmodule

// ===== tb/hw_config_fifo_partition_tb.sv
module hw_config_fifo_partition_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, strap, phy, tx_word, tx_end, rx_word, rx_start;
  logic        tx_err_in, rx_err_in, cmd_valid, cmd_write, paths_halted, tx_sent, rx_read;
  logic [7:0]  cmd_off;
  logic [31:0] cmd_wdata, done_rdata;
  logic [1:0]  done_resp;
  logic        cmd_ready, done, cmd_refused, tx_buf_accept, rx_queue_full, mac_reset;
  logic        got_done, got_ref;
  logic [15:0] tx_data_bytes, rx_data_bytes, rx_stat_bytes;
  int          miscompares, checks, mac_resets;

  hwcf_if bus_if();
  hwcf_dev u_hwcf_dev (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .bus(bus_if),
    .bus_width_strap(strap), .phy_clocks_running(phy), .tx_word_from_queue(tx_word),
    .tx_frame_end(tx_end), .tx_mac_word_sent(tx_sent), .rx_mac_word(rx_word),
    .rx_mac_frame_start(rx_start), .rx_queue_word_read(rx_read), .transmit_error_in(tx_err_in),
    .receive_error_in(rx_err_in), .tx_buf_accept(tx_buf_accept), .rx_queue_full(rx_queue_full),
    .tx_data_bytes(tx_data_bytes), .rx_data_bytes(rx_data_bytes),
    .rx_stat_bytes(rx_stat_bytes), .mac_reset(mac_reset));
  hwcf_host u_hwcf_host (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_off(cmd_off), .cmd_wdata(cmd_wdata),
    .paths_halted(paths_halted), .cmd_ready(cmd_ready), .done(done),
    .done_rdata(done_rdata), .done_resp(done_resp), .cmd_refused(cmd_refused));
  hwcf_asserts u_hwcf_asserts (.aclk(aclk), .aresetn(aresetn), .awaddr(bus_if.awaddr),
    .awvalid(bus_if.awvalid), .awready(bus_if.awready), .wdata(bus_if.wdata),
    .wvalid(bus_if.wvalid), .wready(bus_if.wready), .bresp(bus_if.bresp),
    .bvalid(bus_if.bvalid), .bready(bus_if.bready), .araddr(bus_if.araddr),
    .arvalid(bus_if.arvalid), .arready(bus_if.arready), .rdata(bus_if.rdata),
    .rresp(bus_if.rresp), .rvalid(bus_if.rvalid), .rready(bus_if.rready));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (mac_reset === 1'b1) mac_resets++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task print_verdict;
    $display("Counts: checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One command through the host end; returns after done or refusal
  task automatic cmd(input logic wr, input logic [7:0] off, input logic [31:0] d);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_off   <= off;
    cmd_wdata <= d;
    do @(posedge aclk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    got_done = 1'b0;
    got_ref = 1'b0;
    while (!got_done && !got_ref && n < 200) begin
      @(posedge aclk);
      got_done = (done === 1'b1);
      got_ref = (cmd_refused === 1'b1);
      n++;
    end
    if (n >= 200) chk(32'h0, 32'h1);
  endtask

  task automatic rd(input logic [7:0] off, input logic [31:0] exp);
    cmd(1'b0, off, 32'h0);
    chk(done_rdata, exp);
  endtask

  task t_reset_values;
    cmd(1'b1, 8'h74, 32'h0016_0000);
    rd(8'h74, 32'h0005_0004);
    chk(tx_data_bytes, 32'd4608);
    chk(rx_data_bytes, 32'd10560);
    chk(rx_stat_bytes, 32'd704);
  endtask

  task t_table;
    logic [15:0] tx, rx;
    for (int n = 2; n <= 14; n++) begin
      tx = 16'(n * 1024);
      rx = 16'h4000 - tx;
      cmd(1'b1, 8'h74, 32'h0010_0000 | (32'(n) << 16));
      repeat (2) @(posedge aclk);
      chk(tx_data_bytes, tx - 16'h0200);
      chk(rx_stat_bytes, rx >> 4);
      chk(rx_data_bytes, rx - (rx >> 4));
      rd(8'h7C, {tx - 16'h0200, 16'h0200});
      rd(8'h80, {rx - (rx >> 4), rx >> 4});
    end
  endtask

  // Size 14 leaves 1920 data bytes: full from 476 words on
  task t_rx_full;
    rx_start <= 1'b1;
    @(posedge aclk);
    rx_start <= 1'b0;
    rx_word <= 1'b1;
    repeat (475) @(posedge aclk);
    rx_word <= 1'b0;
    repeat (40) @(posedge aclk);
    chk(rx_queue_full, 32'h0);
    rx_word <= 1'b1;
    @(posedge aclk);
    rx_word <= 1'b0;
    repeat (40) @(posedge aclk);
    chk(rx_queue_full, 32'h1);
    rx_word <= 1'b1;
    repeat (40) @(posedge aclk);
    rx_word <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(8'h78, 32'h1);
    // Reading the queue empty must clear the full flag
    rx_read <= 1'b1;
    repeat (600) @(posedge aclk);
    rx_read <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(rx_queue_full, 32'h0);
  endtask

  task t_tx_frames;
    chk(tx_buf_accept, 32'h1);
    tx_word <= 1'b1;
    tx_end <= 1'b1;
    repeat (2) @(posedge aclk);
    tx_word <= 1'b0;
    tx_end <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(tx_buf_accept, 32'h0);
    // Send both one-word frames, then a third frame must be taken
    tx_sent <= 1'b1;
    repeat (2) @(posedge aclk);
    tx_sent <= 1'b0;
    repeat (2) @(posedge aclk);
    tx_word <= 1'b1;
    tx_end <= 1'b1;
    @(posedge aclk);
    tx_word <= 1'b0;
    tx_end <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(tx_buf_accept, 32'h1);
  endtask

  task t_refused;
    logic [31:0] bad [4];
    bad = '{32'h001E_0000, 32'h0011_0000, 32'h001F_0000, 32'h000E_0000};
    for (int i = 0; i < 4; i++) begin
      paths_halted <= (i != 0);
      @(posedge aclk);
      cmd(1'b1, 8'h74, bad[i]);
      chk(got_ref, 32'h1);
    end
    rd(8'h74, 32'h001E_0004);
    cmd(1'b0, 8'h90, 32'h0);
    chk(done_resp, 32'(hwcf_pkg::HWCF_RESP_SLVERR));
  endtask

  task t_soft_reset;
    phy <= 1'b0;
    tx_err_in <= 1'b1;
    rx_err_in <= 1'b1;
    @(posedge aclk);
    tx_err_in <= 1'b0;
    rx_err_in <= 1'b0;
    repeat (2) @(posedge aclk);
    rd(8'h84, 32'h3);
    cmd(1'b1, 8'h74, 32'h0016_0001);
    rd(8'h74, 32'h0016_0006);
    chk(done_rdata[1], 32'h1);
    chk(mac_resets, 32'h0);
    phy <= 1'b1;
    repeat (4) @(posedge aclk);
    cmd(1'b1, 8'h74, 32'h0016_0001);
    repeat (2) @(posedge aclk);
    chk(mac_resets, 32'h1);
    rd(8'h74, 32'h0005_0004);
    rd(8'h84, 32'h0);
    rd(8'h78, 32'h0);
  endtask

  initial begin
    {aresetn, tx_word, tx_end, rx_word, rx_start, tx_err_in, rx_err_in, tx_sent, rx_read} = '0;
    {cmd_valid, cmd_write, cmd_off, cmd_wdata} = '0;
    {strap, phy, paths_halted} = 3'b111;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_values;
    t_table;
    t_rx_full;
    t_tx_frames;
    t_refused;
    t_soft_reset;
    print_verdict;
  end

  // Whole sequence needs about 1600 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    print_verdict;
  end
endmodule
